// ===== rtl/ipr_regs.sv
// Interrupt priority registers with Wishbone slave and per-source level outputs
//
// How it works
// - Field value 111 gives the source level seven, the highest.
// - Field value 001 gives level one; other values map to their own number.
// - Field value 000 disables the source; its registered request clears on the clock edge after the field is written.
// - Unimplemented bits read zero and ignore writes.
// - priority_ctrl_5 holds only bits 2..0; bits 15..3 are unimplemented.
//
// Decided for this implementation: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module ipr_regs
	import ipr_pkg::*;
#(
	parameter int NSRC = NUM_SRC
) (
	// Clock and reset
	input  wire logic                  sys_clk,
	input  wire logic                  sys_rst,
	// Wishbone slave
	input  wire ipr_wb_req_type        wb_req,
	output logic                       wb_ack,
	output logic [31:0]                wb_dat,
	// Source flags and enables from the flag/enable registers
	input  wire logic [NSRC-1:0]       src_flag,
	input  wire logic [NSRC-1:0]       src_enable,
	// Per-source priority toward the arbiter
	output ipr_src_type [NSRC-1:0]     src_out
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Byte lane that carries a field starting at bit pos
	function automatic int lane_of(input int pos);
		lane_of = pos / 8;
	endfunction : lane_of

	// Level code passes straight through; zero means disabled
	function automatic logic lvl_active(input logic [LVL_W-1:0] lvl);
		lvl_active = (lvl != LVL_OFF);
	endfunction : lvl_active

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	logic                 ack_reg;
	logic [31:0]          dat_reg;
	logic [31:0]          dat_next;
	logic                 bus_req;
	logic                 bus_wr;
	logic                 hit4;
	logic                 hit5;
	logic [15:0]          read4;
	logic [15:0]          read5;
	logic [LVL_W-1:0]     field_val [NSRC];
	logic [NSRC-1:0]      field_wr;

	// A single new request per ack; ack drops the cycle after it rose
	assign bus_req  = wb_req.cyc && wb_req.stb && !ack_reg;
	assign bus_wr   = bus_req && wb_req.we;
	assign hit4     = (wb_req.adr[ADDR_W-1:2] == OFF_PRIO4[ADDR_W-1:2]);
	assign hit5     = (wb_req.adr[ADDR_W-1:2] == OFF_PRIO5[ADDR_W-1:2]);

	// ----------------------------------------------------------------
	// Priority fields
	// ----------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < NSRC; g++) begin : g_field
			logic hit;
			assign hit = (FIELD_REG[g] == 0) ? hit4 : hit5;
			// Byte-lane gated write; only field bits are stored
			assign field_wr[g] = bus_wr && hit && wb_req.sel[lane_of(FIELD_POS[g])];
			ipr_field #(
				.WIDTH (LVL_W),
				.RESET (LVL_RESET)
			) u_field (
				.sys_clk (sys_clk),
				.sys_rst (sys_rst),
				.wr_en   (field_wr[g]),
				.wr_data (wb_req.dat[FIELD_POS[g] +: LVL_W]),
				.value   (field_val[g])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// Read assembly
	// ----------------------------------------------------------------
	// Gaps between fields are constant zero, masked once more for safety
	assign read4 = {1'b0, field_val[SRC_PIN_CHG], 1'b0, field_val[SRC_CMP],
			1'b0, field_val[SRC_COLL], 1'b0, field_val[SRC_EVENT]} & MASK_PRIO4;
	assign read5 = {13'h0000, field_val[SRC_EXT1]} & MASK_PRIO5;

	// Unmapped addresses still ack and read zero, so a stray access never hangs
	assign dat_next = !bus_req        ? dat_reg :
			  hit4            ? {16'h0000, read4} :
			  hit5            ? {16'h0000, read5} :
			                    32'h0000_0000;

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ack_reg <= 1'b0;
			dat_reg <= 32'h0000_0000;
		end else begin
			ack_reg <= bus_req;
			dat_reg <= dat_next;
		end
	end

	assign wb_ack = ack_reg;
	assign wb_dat = dat_reg;

	// ----------------------------------------------------------------
	// Source outputs
	// ----------------------------------------------------------------
	logic [NSRC-1:0] req_reg;
	logic [NSRC-1:0] req_next;
	logic [NSRC-1:0] en_bits;

	generate
		for (g = 0; g < NSRC; g++) begin : g_src
			// Level 0 blocks the source whatever its flag and enable
			assign en_bits[g]  = lvl_active(field_val[g]);
			assign req_next[g] = src_flag[g] && src_enable[g] && en_bits[g];
			// Code is the level: 001 lowest, 111 top
			assign src_out[g].level   = field_val[g];
			assign src_out[g].enabled = en_bits[g];
			assign src_out[g].request = req_reg[g];
		end
	endgenerate

	// Registered so the arbiter sees a glitch-free request
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			req_reg <= '0;
		end else begin
			req_reg <= req_next;
		end
	end

endmodule : ipr_regs
`default_nettype wire

// ===== rtl/ipr_pkg.sv
// Package: register map, field layout and bus carriers for the priority registers
package ipr_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam int          ADDR_W       = 8;
	localparam logic [7:0]  OFF_PRIO4    = 8'h00;
	localparam logic [7:0]  OFF_PRIO5    = 8'h04;

	// ----------------------------------------------------------------
	// Field layout
	// ----------------------------------------------------------------
	localparam int          LVL_W        = 3;
	localparam int          NUM_SRC      = 5;
	localparam int          SRC_PIN_CHG  = 0;
	localparam int          SRC_CMP      = 1;
	localparam int          SRC_COLL     = 2;
	localparam int          SRC_EVENT    = 3;
	localparam int          SRC_EXT1     = 4;
	// Bit position of each field inside its register
	localparam int          FIELD_POS [NUM_SRC] = '{12, 8, 4, 0, 0};
	// Which register holds each field: 0 = priority_ctrl_4, 1 = priority_ctrl_5
	localparam int          FIELD_REG [NUM_SRC] = '{0, 0, 0, 0, 1};
	localparam logic [15:0] MASK_PRIO4   = 16'h7777;
	localparam logic [15:0] MASK_PRIO5   = 16'h0007;

	// ----------------------------------------------------------------
	// Reset values and level codes
	// ----------------------------------------------------------------
	localparam logic [2:0]  LVL_RESET    = 3'h4;
	localparam logic [2:0]  LVL_OFF      = 3'h0;
	localparam logic [2:0]  LVL_TOP      = 3'h7;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic              cyc;
		logic              stb;
		logic              we;
		logic [3:0]        sel;
		logic [ADDR_W-1:0] adr;
		logic [31:0]       dat;
	} ipr_wb_req_type;

	typedef struct packed {
		logic [LVL_W-1:0]  level;
		logic              enabled;
		logic              request;
	} ipr_src_type;

endpackage : ipr_pkg

// ===== rtl/ipr_field.sv
// One software-writable priority field with its power-on value
`timescale 1ns/1ps
`default_nettype none
module ipr_field #(
	parameter int               WIDTH = 3,
	parameter logic [WIDTH-1:0] RESET = 3'h4
) (
	// Clock and reset
	input  wire logic             sys_clk,
	input  wire logic             sys_rst,
	// Write port
	input  wire logic             wr_en,
	input  wire logic [WIDTH-1:0] wr_data,
	// Stored value
	output logic      [WIDTH-1:0] value
);

	logic [WIDTH-1:0] value_reg;
	logic [WIDTH-1:0] value_next;

	assign value_next = wr_en ? wr_data : value_reg;
	assign value      = value_reg;

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			value_reg <= RESET;
		end else begin
			value_reg <= value_next;
		end
	end

endmodule : ipr_field
`default_nettype wire

// ===== testbench/ipr_regs_properties.sv
// Checker: bus timing and level outputs of the priority registers
`timescale 1ns/1ps
`default_nettype none
module ipr_regs_properties
	import ipr_pkg::*;
#(parameter int NSRC = NUM_SRC) (
	// Clock and reset
	input wire logic                  sys_clk,
	input wire logic                  sys_rst,
	// Bus and sources
	input wire ipr_wb_req_type        wb_req,
	input wire logic                  wb_ack,
	input wire logic [31:0]           wb_dat,
	input wire logic [NSRC-1:0]       src_flag,
	input wire logic [NSRC-1:0]       src_enable,
	input wire ipr_src_type [NSRC-1:0] src_out
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	wire tk = wb_req.cyc & wb_req.stb & !wb_ack;
	wire rd = wb_ack & !wb_req.we;
	a_ack_after_take: assert property (tk |=> wb_ack) else $error("no ack");
	a_ack_one_pulse: assert property (wb_ack |=> !wb_ack) else $error("ack too long");
	a_prio4_read_mask: assert property (rd && wb_req.adr == OFF_PRIO4
		|-> (wb_dat & 32'hFFFF8888) == 32'h0) else $error("prio4 stray bits");
	a_prio5_read_mask: assert property (rd && wb_req.adr == OFF_PRIO5
		|-> wb_dat[31:3] == 29'h0) else $error("prio5 stray bits");
	a_ext_field_write: assert property (tk && wb_req.we && wb_req.adr == OFF_PRIO5
		&& wb_req.sel[0] |=> src_out[4].level == $past(wb_req.dat[2:0]))
		else $error("level not written");
	a_off_disables: assert property (src_out[4].enabled == (src_out[4].level != 3'h0))
		else $error("enable wrong");
	a_request_gated: assert property (1'b1 |=> src_out[4].request
		== $past(src_flag[4] & src_enable[4] & src_out[4].enabled)) else $error("request wrong");
	c_top: cover property (src_out[4].level == LVL_TOP);
	c_off: cover property (src_out[4].level == LVL_OFF && src_flag[4] && src_enable[4]);
	c_req: cover property (src_out[4].request);
endmodule : ipr_regs_properties
bind ipr_regs ipr_regs_properties #(.NSRC(NSRC)) u_props (.sys_clk(sys_clk),
	.sys_rst(sys_rst), .wb_req(wb_req), .wb_ack(wb_ack), .wb_dat(wb_dat),
	.src_flag(src_flag), .src_enable(src_enable), .src_out(src_out));
`default_nettype wire

// ===== testbench/test_ipr_regs.sv
// Testbench: random register traffic and level outputs
`timescale 1ns/1ps
`default_nettype none
module test_ipr_regs;
	import ipr_pkg::*;
	logic              sys_clk = 1'b0;
	logic              sys_rst = 1'b1;
	ipr_wb_req_type    wb_req = '0;
	logic              wb_ack;
	logic [31:0]       wb_dat;
	logic [4:0]        src_flag = 5'h0;
	logic [4:0]        src_enable = 5'h0;
	ipr_src_type [4:0] src_out;
	int                n_fail = 0;
	int                cmp_count = 0;
	integer            seed = 25099;
	logic [31:0]       q;
	logic [31:0]       d;
	logic [7:0]        a;
	logic [3:0]        sl = 4'h3;
	logic [2:0]        lv [5] = '{default: LVL_RESET};
	always #20 sys_clk = ~sys_clk;
	ipr_regs dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .wb_req(wb_req), .wb_ack(wb_ack),
		.wb_dat(wb_dat), .src_flag(src_flag), .src_enable(src_enable), .src_out(src_out));
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] dv,
		output logic [31:0] r);
		int t;
		t = 0;
		wb_req <= {2'h3, w, sl, ad, dv};
		do begin
			@(posedge sys_clk);
			t++;
		end while (wb_ack !== 1'b1 && t < 50);
		if (t >= 50) begin
			n_fail++;
			report_and_stop();
		end
		r = wb_dat;
		wb_req <= '0;
		@(posedge sys_clk);
	endtask : wb
	function automatic logic [31:0] mask(input logic [7:0] ad, input logic [31:0] dv);
		return dv & (ad == OFF_PRIO4 ? 32'h7777 : ad == OFF_PRIO5 ? 32'h7 : 32'h0);
	endfunction : mask
	// Shadow of the stored levels, updated per written byte lane
	function automatic void upd(input logic [7:0] ad, input logic [31:0] dv, input logic [3:0] se);
		if (ad == OFF_PRIO4 && se[1]) begin
			lv[0] = dv[14:12];
			lv[1] = dv[10:8];
		end
		if (ad == OFF_PRIO4 && se[0]) begin
			lv[2] = dv[6:4];
			lv[3] = dv[2:0];
		end
		if (ad == OFF_PRIO5 && se[0]) lv[4] = dv[2:0];
	endfunction : upd
	function automatic logic [31:0] exp_rd(input logic [7:0] ad);
		if (ad == OFF_PRIO4) return {17'h0, lv[0], 1'b0, lv[1], 1'b0, lv[2], 1'b0, lv[3]};
		if (ad == OFF_PRIO5) return {29'h0, lv[4]};
		return 32'h0;
	endfunction : exp_rd
	task report_and_stop;
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : report_and_stop
	initial begin
		#200000;
		n_fail++;
		report_and_stop();
	end
	initial begin
		repeat (2) @(posedge sys_clk);
		sys_rst <= 1'b0;
		@(posedge sys_clk);
		wb(1'b0, OFF_PRIO4, 32'h0, q);
		chk("prio4 reset", 32'h4444, q);
		wb(1'b0, OFF_PRIO5, 32'h0, q);
		chk("prio5 reset", 32'h0004, q);
		for (int s = 0; s < 5; s++) begin
			chk("reset level", 32'(LVL_RESET), 32'(src_out[s].level));
		end
		for (int v = 0; v < 8; v++) begin
			d = $random(seed) & 32'hFFFFFFF8 | 32'(v);
			wb(1'b1, OFF_PRIO5, d, q);
			upd(OFF_PRIO5, d, sl);
			wb(1'b0, OFF_PRIO5, 32'h0, q);
			chk("prio5", mask(OFF_PRIO5, d), q);
			chk("ext level", 32'(v), 32'(src_out[4].level));
			chk("ext enabled", 32'(v != 0), 32'(src_out[4].enabled));
		end
		for (int i = 0; i < 20; i++) begin
			d = $random(seed);
			a = (i % 4 == 3) ? 8'h08 : (i % 4 == 2) ? OFF_PRIO5 : OFF_PRIO4;
			sl = 4'($random(seed));
			src_flag <= 5'($random(seed));
			src_enable <= 5'($random(seed));
			wb(1'b1, a, d, q);
			upd(a, d, sl);
			wb(1'b0, a, 32'h0, q);
			chk("readback", exp_rd(a), q);
			for (int s = 0; s < 5; s++) begin
				chk("level", 32'(lv[s]), 32'(src_out[s].level));
				chk("request", 32'(src_flag[s] & src_enable[s] & (lv[s] != 3'h0)),
					32'(src_out[s].request));
			end
		end
		sl = 4'h3;
		src_flag <= 5'h1F;
		src_enable <= 5'h1F;
		wb(1'b1, OFF_PRIO5, 32'h0, q);
		repeat (2) @(posedge sys_clk);
		chk("off request", 32'h0, 32'(src_out[4].request));
		wb(1'b1, OFF_PRIO5, 32'h7, q);
		repeat (2) @(posedge sys_clk);
		chk("top request", 32'h1, 32'(src_out[4].request));
		report_and_stop();
	end
endmodule : test_ipr_regs
`default_nettype wire
